// [rtl/srt_device.sv]
// Module: card end of the suspend/resume request handshake with panel power order
`timescale 1ns/1ps
`default_nettype none
module srt_device #(
    parameter int PANEL_DELAY = srt_pkg::PANEL_DELAY_CYC
) (
    input wire logic SYS_CLK,
    input wire logic SRST,
    srt_if.device LINK,
    input wire logic [7:0] CFG_BYTE,
    input wire logic ALARM_WAKE,
    input wire logic LINE_POL_HIGH,
    input wire logic FRAME_POL_HIGH,
    output logic PANEL_LINE,
    output logic PANEL_FRAME,
    output logic PORT_E_BIT7,
    output logic PANEL_LOGIC_POWER_ON,
    output logic PANEL_BIAS_POWER_ON,
    output logic SUSPENDED,
    output logic CFG_FAULT
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic req_meta;
        logic req_sync;
        logic alarm_meta;
        logic alarm_sync;
        logic [7:0] cfg;
        srt_pkg::srt_state_t state;
        logic [15:0] cnt;
        logic flag;
        logic sleep_n;
        logic logic_pwr;
        logic bias_pwr;
        logic lines_on;
        logic line;
        logic frame;
        logic susp;
        logic fault;
        logic [2:0] pins;
    } srt_dev_t;

    srt_dev_t r;
    srt_dev_t next_r;
    logic unconfirmed;
    logic req_low;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_r = r;
        // Two flops: request and alarm arrive from off the card
        next_r.req_meta = LINK.port_c_bit0;
        next_r.req_sync = r.req_meta;
        next_r.alarm_meta = ALARM_WAKE;
        next_r.alarm_sync = r.alarm_meta;
        unconfirmed = r.cfg[srt_pkg::CFG_METHOD_BIT];
        req_low = !r.req_sync; // Level, not edge
        // One down counter serves both panel delays
        if (r.cnt != srt_pkg::CNT_ZERO) begin
            next_r.cnt = r.cnt - 16'h0001;
        end
        // ************************************************************
        // Sequence
        // ************************************************************
        case (r.state)
            srt_pkg::SRT_RUN: begin
                // Settings follow the byte only while idle, so no sequence is torn
                next_r.cfg = CFG_BYTE & 8'hE3;
                next_r.fault = !(CFG_BYTE[7:5] == 3'h0 || CFG_BYTE[7:5] == 3'h1
                    || CFG_BYTE[7:5] == 3'h2 || CFG_BYTE[7:5] == 3'h4);
                if (req_low && !r.flag) begin
                    next_r.state = srt_pkg::SRT_ACCEPT_SUSP;
                end
            end
            srt_pkg::SRT_ACCEPT_SUSP: begin
                next_r.flag = 1'b1;
                next_r.state = unconfirmed ? srt_pkg::SRT_SLEEP
                    : srt_pkg::SRT_WAIT_HIGH_SUSP;
            end
            srt_pkg::SRT_WAIT_HIGH_SUSP: begin
                if (!req_low) begin
                    next_r.state = srt_pkg::SRT_SLEEP;
                end
            end
            srt_pkg::SRT_SLEEP: begin
                next_r.flag = 1'b0;
                next_r.sleep_n = 1'b0;
                next_r.lines_on = 1'b0;
                next_r.cnt = PANEL_DELAY[15:0];
                next_r.state = srt_pkg::SRT_PANEL_OFF;
            end
            srt_pkg::SRT_PANEL_OFF: begin
                if (r.cnt == srt_pkg::CNT_ZERO) begin
                    next_r.logic_pwr = 1'b0;
                    next_r.bias_pwr = 1'b0;
                    next_r.susp = 1'b1;
                    next_r.state = srt_pkg::SRT_SUSPENDED;
                end
            end
            srt_pkg::SRT_SUSPENDED: begin
                // Alarm only wakes when enabled
                if ((req_low && !r.flag)
                    || (r.cfg[srt_pkg::CFG_ALARM_BIT] && r.alarm_sync)) begin
                    next_r.state = srt_pkg::SRT_ACCEPT_RES;
                end
            end
            srt_pkg::SRT_ACCEPT_RES: begin
                next_r.flag = req_low; // Alarm wake needs no release
                next_r.state = (unconfirmed || !req_low) ? srt_pkg::SRT_PANEL_ON
                    : srt_pkg::SRT_WAIT_HIGH_RES;
            end
            srt_pkg::SRT_WAIT_HIGH_RES: begin
                if (!req_low) begin
                    next_r.state = srt_pkg::SRT_PANEL_ON;
                end
            end
            srt_pkg::SRT_PANEL_ON: begin
                next_r.flag = 1'b0;
                next_r.logic_pwr = 1'b1; // Power first
                next_r.bias_pwr = 1'b1;
                next_r.susp = 1'b0;
                next_r.cnt = PANEL_DELAY[15:0];
                next_r.state = srt_pkg::SRT_LINES_ON;
            end
            srt_pkg::SRT_LINES_ON: begin
                if (r.cnt == srt_pkg::CNT_ZERO) begin
                    // Lines and wake share an edge; sleep alone would hold lines low
                    next_r.lines_on = 1'b1; // Then lines
                    next_r.sleep_n = 1'b1; // Leave sleep on that same edge
                    next_r.state = srt_pkg::SRT_RUN;
                end
            end
            default: begin
                next_r.state = srt_pkg::SRT_RUN;
            end
        endcase
        // ************************************************************
        // Panel and flag outputs
        // ************************************************************
        // Inactive level is the polarity, but never high while lines are off
        next_r.line = next_r.lines_on & LINE_POL_HIGH;
        next_r.frame = next_r.lines_on & FRAME_POL_HIGH;
        // Flag is active low, on the selected pin only
        next_r.pins = ~({3{next_r.flag}}
            & next_r.cfg[srt_pkg::CFG_FLAG_MSB:srt_pkg::CFG_FLAG_LSB]);
        // A prohibited selection shows no flag rather than two or three
        if (next_r.fault) begin
            next_r.pins = 3'h7;
        end
    end

    // ************************************************************
    // Register
    // ************************************************************
    // Out of reset the panel stays powered and awake, request idle high
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            r <= '0;
            r.state <= srt_pkg::SRT_RUN;
            r.req_meta <= 1'b1;
            r.req_sync <= 1'b1;
            r.cfg <= srt_pkg::CFG_RESET;
            r.sleep_n <= 1'b1;
            r.logic_pwr <= 1'b1;
            r.bias_pwr <= 1'b1;
            r.lines_on <= 1'b1;
            r.pins <= 3'h7;
        end else begin
            r <= next_r;
        end
    end

    // ************************************************************
    // Outputs, each straight from the state register
    // ************************************************************
    assign LINK.port_c_bit7 = r.pins[2];
    assign LINK.port_c_bit6 = r.pins[1];
    assign LINK.port_c_bit5 = r.pins[0];
    assign PANEL_LINE = r.line;
    assign PANEL_FRAME = r.frame;
    assign PORT_E_BIT7 = r.sleep_n;
    assign PANEL_LOGIC_POWER_ON = r.logic_pwr;
    assign PANEL_BIAS_POWER_ON = r.bias_pwr;
    assign SUSPENDED = r.susp;
    assign CFG_FAULT = r.fault;
endmodule
`default_nettype wire

// [rtl/srt_if.sv]
// Interface: request line and release flag port bits between card and trigger circuit
`timescale 1ns/1ps
`default_nettype none
interface srt_if;
    logic port_c_bit0;
    logic port_c_bit7;
    logic port_c_bit6;
    logic port_c_bit5;
    modport device (input port_c_bit0, output port_c_bit7, output port_c_bit6,
        output port_c_bit5);
    modport trigger (output port_c_bit0, input port_c_bit7, input port_c_bit6,
        input port_c_bit5);
endinterface
`default_nettype wire

// [rtl/srt_pkg.sv]
// Package: constants and types used by the card end of the suspend/resume trigger link
`default_nettype none
package srt_pkg;
    // ************************************************************
    // Configuration byte layout
    // ************************************************************
    localparam int CFG_ALARM_BIT = 0;
    localparam int CFG_METHOD_BIT = 1;
    localparam int CFG_FLAG_LSB = 5;
    localparam int CFG_FLAG_MSB = 7;
    localparam logic [7:0] CFG_FLAG_BIT7 = 8'h80;
    localparam logic [7:0] CFG_FLAG_BIT6 = 8'h40;
    localparam logic [7:0] CFG_FLAG_BIT5 = 8'h20;
    localparam logic [7:0] CFG_FLAG_NONE = 8'h00;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_MHZ = 200;
    localparam int PANEL_DELAY_US = 10;
    localparam int PANEL_DELAY_CYC = PANEL_DELAY_US * CLK_MHZ;
    localparam int MIN_LOW_CYC = 4;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    // ************************************************************
    // Device sequence states
    // ************************************************************
    typedef enum logic [3:0] {
        SRT_RUN = 4'h0,
        SRT_ACCEPT_SUSP = 4'h1,
        SRT_WAIT_HIGH_SUSP = 4'h2,
        SRT_SLEEP = 4'h3,
        SRT_PANEL_OFF = 4'h4,
        SRT_SUSPENDED = 4'h5,
        SRT_ACCEPT_RES = 4'h6,
        SRT_WAIT_HIGH_RES = 4'h7,
        SRT_PANEL_ON = 4'h8,
        SRT_LINES_ON = 4'h9
    } srt_state_t;
endpackage
`default_nettype wire

// [rtl/srt_trigger.sv]
// Module: carrier-board trigger circuit driving the request line
`timescale 1ns/1ps
`default_nettype none
module srt_trigger (
    input wire logic SYS_CLK,
    input wire logic SRST,
    srt_if.trigger LINK,
    input wire logic TRIGGER_EVENT,
    input wire logic LEVEL_MODE,
    input wire logic [2:0] FLAG_SELECT,
    output logic REQ_PENDING
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [2:0] flag_meta;
        logic [2:0] flag_sync;
        logic ev_meta;
        logic ev_sync;
        logic ev_prev;
        logic latch;
        logic req_n;
    } srt_trg_t;

    srt_trg_t r;
    srt_trg_t next_r;
    logic flag_seen;

    always_comb begin
        next_r = r;
        next_r.flag_meta = {LINK.port_c_bit7, LINK.port_c_bit6, LINK.port_c_bit5};
        next_r.flag_sync = r.flag_meta;
        next_r.ev_meta = TRIGGER_EVENT;
        next_r.ev_sync = r.ev_meta;
        next_r.ev_prev = r.ev_sync;
        flag_seen = |(~r.flag_sync & FLAG_SELECT);
        if (LEVEL_MODE) begin
            next_r.latch = r.ev_sync; // Held low for suspend
        end else if (flag_seen) begin
            next_r.latch = 1'b0; // Release only after flag
        end else if (r.ev_sync && !r.ev_prev) begin
            next_r.latch = 1'b1; // Latched pulse, held until flag
        end
        next_r.req_n = !next_r.latch; // High, low, high
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            r <= '0;
            r.flag_meta <= 3'h7;
            r.flag_sync <= 3'h7;
            r.req_n <= 1'b1; // Reset clears request high
        end else begin
            r <= next_r;
        end
    end

    assign LINK.port_c_bit0 = r.req_n;
    assign REQ_PENDING = r.latch;
endmodule
`default_nettype wire

// [sim/srt_link_props.sv]
// Checker: assertions on the request link and the panel outputs
`timescale 1ns/1ps
`default_nettype none
module srt_link_props (
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic port_c_bit0,
    input wire logic port_c_bit7,
    input wire logic port_c_bit6,
    input wire logic port_c_bit5,
    input wire logic PANEL_LINE,
    input wire logic PANEL_FRAME,
    input wire logic PORT_E_BIT7,
    input wire logic PANEL_LOGIC_POWER_ON,
    input wire logic PANEL_BIAS_POWER_ON,
    input wire logic SUSPENDED
);
    logic flag_on;
    assign flag_on = !(port_c_bit7 && port_c_bit6 && port_c_bit5);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SRST);
    // ****************************************
    // Assertions
    // ****************************************
    chk_reset_idle: assert property ($fell(SRST) |-> port_c_bit0 && !flag_on
        && PORT_E_BIT7 && PANEL_LOGIC_POWER_ON && !SUSPENDED) else $error("reset state");
    chk_one_flag: assert property ($onehot0({!port_c_bit7, !port_c_bit6, !port_c_bit5}))
        else $error("two flags low");
    chk_flag_on_request: assert property ($rose(flag_on) |-> !port_c_bit0)
        else $error("flag without request");
    chk_flag_drops: assert property (flag_on |-> ##[1:24] !flag_on)
        else $error("flag stuck");
    chk_sleep_lines: assert property (!PORT_E_BIT7 |-> !PANEL_LINE && !PANEL_FRAME)
        else $error("line high in sleep");
    chk_power_pair: assert property (PANEL_LOGIC_POWER_ON == PANEL_BIAS_POWER_ON)
        else $error("supplies differ");
    chk_power_order: assert property (!PANEL_LOGIC_POWER_ON |-> !PORT_E_BIT7)
        else $error("awake without power");
    chk_power_delay: assert property ($fell(PORT_E_BIT7) |->
        PANEL_LOGIC_POWER_ON ##[6:10] !PANEL_LOGIC_POWER_ON) else $error("power off late");
    chk_resume_order: assert property ($rose(PORT_E_BIT7) |-> $past(PANEL_LOGIC_POWER_ON, 6))
        else $error("wake before power");
    cover property ($rose(flag_on));
    cover property ($rose(SUSPENDED));
    cover property ($fell(SUSPENDED));
endmodule
`default_nettype wire

// [sim/suspend_resume_trigger_test.sv]
// Testbench: both ends joined, suspend and resume scenarios
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin num_errors++; \
    $display("BAD %0t mismatch", $time); end end
module suspend_resume_trigger_test;
    logic SYS_CLK = 1'b0;
    logic SRST = 1'b1;
    logic ALARM_WAKE = 1'b0;
    logic LINE_POL_HIGH = 1'b1;
    logic FRAME_POL_HIGH = 1'b1;
    logic TRIGGER_EVENT = 1'b0;
    logic [7:0] CFG_BYTE = 8'h80;
    logic PANEL_LINE, PANEL_FRAME, PORT_E_BIT7, SUSPENDED, CFG_FAULT, REQ_PENDING;
    logic PANEL_LOGIC_POWER_ON, PANEL_BIAS_POWER_ON;
    logic [2:0] seen = 3'h0;
    logic seen_clr = 1'b0;
    int num_errors = 0;
    int num_checks = 0;
    srt_if link();
    always #2.5 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK) begin
        seen <= seen_clr ? 3'h0
            : (seen | ~{link.port_c_bit7, link.port_c_bit6, link.port_c_bit5});
    end
    srt_device #(.PANEL_DELAY(8)) srt_device_i (.SYS_CLK, .SRST, .LINK(link), .CFG_BYTE,
        .ALARM_WAKE, .LINE_POL_HIGH, .FRAME_POL_HIGH, .PANEL_LINE, .PANEL_FRAME, .PORT_E_BIT7,
        .PANEL_LOGIC_POWER_ON, .PANEL_BIAS_POWER_ON, .SUSPENDED, .CFG_FAULT);
    srt_trigger srt_trigger_i (.SYS_CLK, .SRST, .LINK(link), .TRIGGER_EVENT,
        .LEVEL_MODE(CFG_BYTE[1]), .FLAG_SELECT(CFG_BYTE[7:5]), .REQ_PENDING);
    srt_link_props srt_link_props_i (.SYS_CLK, .SRST, .port_c_bit0(link.port_c_bit0),
        .port_c_bit7(link.port_c_bit7), .port_c_bit6(link.port_c_bit6),
        .port_c_bit5(link.port_c_bit5), .PANEL_LINE, .PANEL_FRAME, .PORT_E_BIT7,
        .PANEL_LOGIC_POWER_ON, .PANEL_BIAS_POWER_ON, .SUSPENDED);
    // ****************************************
    // Helpers
    // ****************************************
    task step(int n);
        repeat (n) @(posedge SYS_CLK);
        #1;
    endtask
    task wait_susp(logic v);
        int k;
        k = 0;
        while (SUSPENDED !== v && k < 200) begin
            step(1);
            k++;
        end
        `CHK(SUSPENDED, v)
    endtask
    // Event held a while so the synchroniser cannot miss it
    task press();
        TRIGGER_EVENT = 1'b1;
        step(12);
        TRIGGER_EVENT = 1'b0;
        step(2);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task clear_seen();
        seen_clr = 1'b1;
        step(1);
        seen_clr = 1'b0;
    endtask
    task t_round(logic [7:0] cfg);
        CFG_BYTE = cfg;
        step(4);
        clear_seen();
        press();
        wait_susp(1'b1);
        `CHK(REQ_PENDING, 1'b0)
        `CHK({PORT_E_BIT7, PANEL_LINE, PANEL_FRAME, PANEL_LOGIC_POWER_ON}, 4'h0)
        `CHK(seen, cfg[7:5])
        ALARM_WAKE = 1'b1;
        step(30);
        `CHK(SUSPENDED, 1'b1)
        ALARM_WAKE = 1'b0;
        clear_seen();
        press();
        wait_susp(1'b0);
        `CHK(seen, cfg[7:5])
        step(20);
        `CHK({PORT_E_BIT7, PANEL_LINE, PANEL_FRAME, PANEL_BIAS_POWER_ON}, 4'hF)
    endtask
    task t_alarm();
        CFG_BYTE = 8'h21;
        step(4);
        press();
        wait_susp(1'b1);
        ALARM_WAKE = 1'b1;
        step(4);
        ALARM_WAKE = 1'b0;
        wait_susp(1'b0);
        step(20);
        `CHK({PORT_E_BIT7, PANEL_FRAME, PANEL_LOGIC_POWER_ON}, 3'h7)
    endtask
    task t_fault();
        CFG_BYTE = 8'hA0;
        step(4);
        `CHK(CFG_FAULT, 1'b1)
        CFG_BYTE = 8'h40;
        step(4);
        `CHK(CFG_FAULT, 1'b0)
    endtask
    // Held request in the unconfirmed method keeps cycling; a reset ends it
    task t_unconf();
        CFG_BYTE = 8'h42;
        step(4);
        TRIGGER_EVENT = 1'b1;
        wait_susp(1'b1);
        `CHK(REQ_PENDING, 1'b1)
        wait_susp(1'b0);
        wait_susp(1'b1);
        TRIGGER_EVENT = 1'b0;
        SRST = 1'b1;
        step(6);
        SRST = 1'b0;
        step(3);
        `CHK({link.port_c_bit0, SUSPENDED, PANEL_LINE}, 3'b101)
    endtask
    task final_report();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #50000;
        num_errors++;
        final_report();
    end
    initial begin
        step(6);
        SRST = 1'b0;
        step(3);
        `CHK({link.port_c_bit0, PORT_E_BIT7, PANEL_LINE, PANEL_LOGIC_POWER_ON}, 4'hF)
        for (int i = 0; i < 3; i++) begin
            t_round(8'h80 >> i);
        end
        t_alarm();
        t_fault();
        t_unconf();
        final_report();
    end
endmodule
`default_nettype wire
